// ### hdl/sensor_error_and_interrupt_logic.sv
// Error flags, switch results, data ready and the two interrupt pins.
// Assumes a measurement engine giving one store pulse with raw results,
// and an APB master; the bus always completes with no wait state.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "sensor_irq_defines.svh"
module sensor_error_and_interrupt_logic #(
  parameter logic [15:0] clamp_high_sens = `CLAMP_HIGH_SENS,
  parameter logic [15:0] clamp_wide = `CLAMP_WIDE
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement engine.
  input wire logic meas_done,
  input wire sensor_irq_pkg::raw_t raw,
  // Interrupt pins and the bus interrupt.
  output logic push_pull_irq_pin,
  output logic open_drain_irq_pin_o,
  output logic open_drain_irq_pin_oe,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////
  function automatic logic in_range(input logic [5:0] v, input logic [5:0] lo,
                                    input logic [5:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [15:0] clamp_axis(input logic [15:0] v, input logic over,
                                             input logic [15:0] c);
    if (!over) begin
      clamp_axis = v;
    end else if (v[15]) begin
      clamp_axis = 16'(~c + 16'h0001);
    end else begin
      clamp_axis = c;
    end
  endfunction

  sensor_irq_pkg::ctrl_t ctrl_ff;
  logic [15:0] x_ff, y_ff, z_ff;
  logic data_ready_flag_ff, planar_ff, conv_ff, sw_chg_ff, pending_ff;
  logic [5:0] sw_ff, nxt_sw;
  logic [3:0] evt_ff, mask_ff;
  logic [5:0] idx;
  logic aligned, mapped, done, rd_release, wr_release, release_acc, release_done;
  logic data_rd_done, cond, active, sw_change;
  logic [15:0] clamp_code;

  //////////////////////////////////////////////////////////////////////
  assign idx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign done = psel && penable;
  assign mapped = aligned && (idx == `IDX_STATUS || idx == `IDX_X || idx == `IDX_Y ||
                  idx == `IDX_Z || idx == `IDX_CTRL || idx == `IDX_EVT || idx == `IDX_MASK);
  assign pready = 1'b1;
  assign pslverr = done && !mapped;
  // The release covers both bus phases so the pins stay idle the whole access.
  assign rd_release = psel && !pwrite && aligned && in_range(idx, `RD_LO, `RD_HI);
  assign wr_release = psel && pwrite && aligned && in_range(idx, `WR_LO, `WR_HI);
  assign release_acc = rd_release || wr_release;
  assign release_done = release_acc && penable;
  assign data_rd_done = done && !pwrite && aligned &&
                        (idx == `IDX_X || idx == `IDX_Y || idx == `IDX_Z);

  always_comb begin
    prdata = 32'h0000_0000;
    if (done && !pwrite && aligned) begin
      unique case (idx)
        `IDX_STATUS: prdata = {23'h000000, sw_ff, conv_ff, planar_ff, data_ready_flag_ff};
        `IDX_X: prdata = {16'h0000, x_ff};
        `IDX_Y: prdata = {16'h0000, y_ff};
        `IDX_Z: prdata = {16'h0000, z_ff};
        `IDX_CTRL: prdata = {20'h00000, ctrl_ff};
        `IDX_EVT: prdata = {28'h0000000, evt_ff};
        `IDX_MASK: prdata = {28'h0000000, mask_ff};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `CTRL_RST;
    end else if (done && pwrite && aligned && idx == `IDX_CTRL) begin
      ctrl_ff <= pwdata[11:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_ff <= 4'h0;
    end else if (done && pwrite && aligned && idx == `IDX_MASK) begin
      mask_ff <= pwdata[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  assign clamp_code = ctrl_ff.wide_range ? clamp_wide : clamp_high_sens;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      x_ff <= 16'h0000;
      y_ff <= 16'h0000;
      z_ff <= 16'h0000;
      planar_ff <= 1'b0;
      conv_ff <= 1'b0;
    end else if (meas_done) begin
      x_ff <= clamp_axis(raw.x, raw.x_over, clamp_code);
      y_ff <= clamp_axis(raw.y, raw.y_over, clamp_code);
      z_ff <= raw.z;
      planar_ff <= raw.x_over || raw.y_over;
      conv_ff <= raw.adc_over;
    end
  end

  always_comb begin
    nxt_sw = sw_ff;
    for (int i = 0; i < 6; i++) begin
      if (raw.sw_above[i]) begin
        nxt_sw[i] = 1'b1;
      end else if (raw.sw_below[i]) begin
        nxt_sw[i] = 1'b0;
      end
    end
  end

  assign sw_change = |((nxt_sw ^ sw_ff) & ctrl_ff.switch_event_enable);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_ff <= 6'h00;
    end else if (meas_done) begin
      sw_ff <= nxt_sw;
    end
  end

  // Each flag below lets a new store win over a clear in the same cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_chg_ff <= 1'b0;
    end else if (meas_done) begin
      sw_chg_ff <= sw_change;
    end else if (release_done) begin
      sw_chg_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_ready_flag_ff <= 1'b0;
    end else if (meas_done) begin
      data_ready_flag_ff <= 1'b1;
    end else if (data_rd_done || (wr_release && penable)) begin
      data_ready_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_ff <= 1'b0;
    end else if (meas_done) begin
      pending_ff <= 1'b1;
    end else if (release_done) begin
      pending_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // gated sources
  assign cond = (ctrl_ff.data_ready_event_enable && data_ready_flag_ff) ||
                (ctrl_ff.planar_overflow_event_enable && planar_ff) ||
                (ctrl_ff.converter_overflow_event_enable && conv_ff) || sw_chg_ff;
  assign active = pending_ff && cond && !release_acc;
  assign push_pull_irq_pin = active && ctrl_ff.push_pull_pin_enable;
  assign open_drain_irq_pin_oe = active && ctrl_ff.open_drain_pin_enable;
  assign open_drain_irq_pin_o = 1'b0;

  // Sticky copies for software; a write of one clears, a new event wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_ff <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (meas_done && ((i == `EVT_DATA_READY_FLAG) || (i == `EVT_PLANAR &&
            (raw.x_over || raw.y_over)) || (i == `EVT_CONV && raw.adc_over) ||
            (i == `EVT_SWITCH && sw_change))) begin
          evt_ff[i] <= 1'b1;
        end else if (done && pwrite && aligned && idx == `IDX_EVT && pwdata[i]) begin
          evt_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(evt_ff & mask_ff);

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_clamp;
    meas_done && raw.x_over && !raw.x[15] && !ctrl_ff.wide_range
      |=> x_ff == clamp_high_sens;
  endproperty
  a_clamp: assert property (p_clamp) else $error("X clamp code wrong.");

  property p_planar;
    meas_done |=> planar_ff == $past(raw.x_over || raw.y_over);
  endproperty
  a_planar: assert property (p_planar) else $error("Planar flag wrong.");

  property p_follow;
    meas_done && !raw.y_over |=> y_ff == $past(raw.y);
  endproperty
  a_follow: assert property (p_follow) else $error("Y not updated.");

  property p_conv;
    meas_done && raw.adc_over |=> conv_ff;
  endproperty
  a_conv: assert property (p_conv) else $error("Converter flag not set.");

  property p_conv_clr;
    meas_done && !raw.adc_over |=> !conv_ff;
  endproperty
  a_conv_clr: assert property (p_conv_clr) else $error("Converter flag stale.");

  property p_switch;
    meas_done && sw_change |=> sw_chg_ff;
  endproperty
  a_switch: assert property (p_switch) else $error("Switch event lost.");

  property p_disabled;
    !ctrl_ff.push_pull_pin_enable |-> !push_pull_irq_pin;
  endproperty
  a_disabled: assert property (p_disabled) else $error("Push-pull pin active.");

  property p_assert;
    meas_done && ctrl_ff.data_ready_event_enable && ctrl_ff.push_pull_pin_enable &&
      ctrl_ff.open_drain_pin_enable && !(psel && pwrite)
      |=> release_acc || (push_pull_irq_pin && open_drain_irq_pin_oe);
  endproperty
  a_assert: assert property (p_assert) else $error("Pins not asserted.");

  property p_idle;
    !cond |-> !push_pull_irq_pin && !open_drain_irq_pin_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("Pin active without event.");

  property p_release;
    release_acc |-> !push_pull_irq_pin && !open_drain_irq_pin_oe;
  endproperty
  a_release: assert property (p_release) else $error("Pin active in access.");

  property p_rel_hold;
    release_done && !meas_done |=> !push_pull_irq_pin && !open_drain_irq_pin_oe;
  endproperty
  a_rel_hold: assert property (p_rel_hold) else $error("Pin not released.");

  property p_data_ready_flag;
    meas_done |=> data_ready_flag_ff;
  endproperty
  a_data_ready_flag: assert property (p_data_ready_flag) else $error("Data ready not set.");

  property p_od_disabled;
    !ctrl_ff.open_drain_pin_enable |-> !open_drain_irq_pin_oe;
  endproperty
  a_od_disabled: assert property (p_od_disabled) else $error("Open-drain pin active.");

  property p_same;
    push_pull_irq_pin && ctrl_ff.open_drain_pin_enable |-> open_drain_irq_pin_oe &&
      !open_drain_irq_pin_o;
  endproperty
  a_same: assert property (p_same) else $error("Pins disagree.");

  // One source alone must be enough to drive the pin.
  property p_or;
    pending_ff && !release_acc && ctrl_ff.push_pull_pin_enable &&
      ctrl_ff.converter_overflow_event_enable && conv_ff |-> push_pull_irq_pin;
  endproperty
  a_or: assert property (p_or) else $error("Source not combined onto pin.");

  property p_irq;
    meas_done && mask_ff[`EVT_DATA_READY_FLAG] && !(psel && pwrite) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not raised.");

  c_pins: cover property (meas_done ##1 push_pull_irq_pin ##[1:20] release_done);
  c_release_write: cover property (wr_release && penable && pending_ff);
  c_clamp: cover property (meas_done && raw.x_over);
  c_switch: cover property (meas_done && sw_change ##1 open_drain_irq_pin_oe);

endmodule

// ### hdl/sensor_irq_defines.svh
// Constants of the sensor error flag and interrupt pin block.
// Assumes an APB master with 32-bit data; registers sit at four times their index.
// Summary of operation
// - An X or Y overflow stores the clamp code chosen by the range setting, negated for a negative raw code.
// - Any X or Y overflow in a measurement sets the planar overflow flag.
// - Once back in range, X, Y and the planar flag follow new measurements.
// - A converter overflow sets the converter overflow flag, marking data invalid.
// - The converter overflow flag is re-evaluated at every stored measurement.
// - Two interrupt pins: one push-pull, one open-drain, same event indication.
// - Four event sources: data ready, planar, converter overflow, switch change.
// - A source counts only when its own enable and its status flag are one; the switch enables are applied at the store.
// - A switch event is any enabled switch result bit changing in either direction.
// - Each pin has its own enable; disabled, push-pull stays low, open-drain released.
// - Enabled event and pin enable: push-pull goes high, open-drain pulls low.
// - With no enabled event present both pins stay idle whatever the enables.
// - Push-pull rises at measurement end, held low during reads 10h-1Fh, writes 20h-27h.
// - Open-drain pulls low at measurement end, released during the same accesses.
// - Data ready sets on store, clears on data register read or setting write.
// - Switch bit sets above operating, clears below returning threshold, per store.
`ifndef SENSOR_IRQ_DEFINES_SVH
`define SENSOR_IRQ_DEFINES_SVH
`define IDX_STATUS 6'h10
`define IDX_X 6'h11
`define IDX_Y 6'h12
`define IDX_Z 6'h13
`define IDX_CTRL 6'h20
`define IDX_EVT 6'h30
`define IDX_MASK 6'h31
`define RD_LO 6'h10
`define RD_HI 6'h1F
`define WR_LO 6'h20
`define WR_HI 6'h27
`define CTRL_RST 12'h000
`define CLAMP_HIGH_SENS 16'h7FFB
`define CLAMP_WIDE 16'h2BFD
`define EVT_DATA_READY_FLAG 0
`define EVT_PLANAR 1
`define EVT_CONV 2
`define EVT_SWITCH 3
`endif

// ### hdl/sensor_irq_pkg.sv
// Types of the sensor error flag and interrupt pin block.
// Assumes the constants header is included by each user.
package sensor_irq_pkg;
  typedef struct packed {
    logic wide_range;
    logic open_drain_pin_enable;
    logic push_pull_pin_enable;
    logic [5:0] switch_event_enable;
    logic converter_overflow_event_enable;
    logic planar_overflow_event_enable;
    logic data_ready_event_enable;
  } ctrl_t;
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic x_over;
    logic y_over;
    logic adc_over;
    logic [5:0] sw_above;
    logic [5:0] sw_below;
  } raw_t;
endpackage

// ### tb/irq_host_model.sv
// Host side of the open-drain interrupt wire.
// Assumes the block gives a level and an enable; the board pulls the wire up.
`timescale 1ns/1ps
module irq_host_model (
  // Pin as driven by the block.
  input wire logic od_o,
  input wire logic od_oe,
  // Level that the host sees.
  output logic od_level
);
  assign od_level = od_oe ? od_o : 1'b1;
endmodule

// ### tb/tb.sv
// Self-checking bench of the sensor error flag and interrupt pin block.
// Assumes an APB slave and the host model on the open-drain wire.
`timescale 1ns/1ps
`include "sensor_irq_defines.svh"
module tb;
  logic clk, rst, psel, penable, pwrite, meas_done, pready, pslverr;
  logic pp, od_o, od_oe, od_level, irq, pp_acc, od_acc, err, wide;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [95:0] rnd;
  logic [5:0] sw_model;
  sensor_irq_pkg::raw_t raw, r;
  int n_mismatch = 0;
  int checks = 0;
  sensor_error_and_interrupt_logic dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_done(meas_done), .raw(raw),
    .push_pull_irq_pin(pp), .open_drain_irq_pin_o(od_o), .open_drain_irq_pin_oe(od_oe),
    .irq(irq));
  irq_host_model host (.od_o(od_o), .od_oe(od_oe), .od_level(od_level));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    #1;
    pp_acc = pp;
    od_acc = od_level;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic measure(input sensor_irq_pkg::raw_t m);
    @(posedge clk);
    raw <= m;
    meas_done <= 1'b1;
    @(posedge clk);
    meas_done <= 1'b0;
    sw_model = exp_sw(sw_model, m.sw_above, m.sw_below);
    #1;
  endtask
  // A switch bit sets above operating, clears below returning, else holds.
  function automatic logic [5:0] exp_sw(input logic [5:0] prev, input logic [5:0] above,
                                        input logic [5:0] below);
    return (prev & ~below) | above;
  endfunction
  // A clamped axis keeps the sign of the raw code.
  function automatic logic [15:0] exp_axis(input logic [15:0] v, input logic over,
                                           input logic wr_wide);
    logic [15:0] c;
    c = wr_wide ? `CLAMP_WIDE : `CLAMP_HIGH_SENS;
    if (!over) return v;
    return v[15] ? -c : c;
  endfunction
  task automatic close_out;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    n_mismatch++;
    close_out();
  end
  initial begin
    void'($urandom(74014));
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    meas_done = 1'b0;
    raw = '0;
    sw_model = 6'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h80, 32'h0);
    chk("ctrl reset", 32'(`CTRL_RST), q);
    apb(1'b0, 8'hF0, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    for (int i = 0; i < 40; i++) begin
      rnd = {$urandom, $urandom, $urandom};
      r = rnd[62:0];
      wide = rnd[95];
      apb(1'b1, 8'h80, 32'(wide) << 11);
      measure(r);
      apb(1'b0, 8'h44, 32'h0);
      chk("x result", 32'(exp_axis(r.x, r.x_over, wide)), q);
      apb(1'b0, 8'h48, 32'h0);
      chk("y result", 32'(exp_axis(r.y, r.y_over, wide)), q);
      apb(1'b0, 8'h4C, 32'h0);
      chk("z result", 32'(r.z), q);
      apb(1'b0, 8'h40, 32'h0);
      chk("status flags", {29'h0, r.adc_over, r.x_over | r.y_over, 1'b0},
          32'(q[2:0]));
      chk("switch results", 32'(sw_model), 32'(q[8:3]));
    end
    for (int k = 0; k < 5; k++) begin
      for (int pe = 0; pe < 4; pe++) begin
        r = '0;
        r.sw_below = 6'h3F;
        measure(r);
        apb(1'b1, 8'h80, ((k < 4) ? (32'h1 << k) : 32'h0) | (32'(pe) << 9));
        r = '0;
        r.x_over = (k == 1);
        r.adc_over = (k == 2);
        r.sw_above = {5'h0, k == 3};
        measure(r);
        chk("push-pull pin", 32'((k < 4) && pe[0]), 32'(pp));
        chk("open-drain pin", 32'(!((k < 4) && pe[1])), 32'(od_level));
        apb(1'b0, 8'h40, 32'h0);
        chk("pins during read", 32'h2, {30'h0, od_acc, pp_acc});
        chk("pins after read", 32'h2, {30'h0, od_level, pp});
      end
    end
    apb(1'b1, 8'h80, 32'h0000060E);
    r = '0;
    r.x_over = 1'b1;
    r.adc_over = 1'b1;
    measure(r);
    chk("ored sources", 32'h1, 32'(pp));
    r.x_over = 1'b0;
    measure(r);
    chk("single source", 32'h1, 32'(pp));
    apb(1'b1, 8'hC4, 32'h1);
    apb(1'b0, 8'hC4, 32'h0);
    chk("mask register", 32'h1, q);
    apb(1'b1, 8'hC0, 32'hF);
    measure('0);
    chk("irq raised", 32'h1, 32'(irq));
    apb(1'b0, 8'hC0, 32'h0);
    chk("event register", 32'h1, q);
    apb(1'b1, 8'hC0, 32'h1);
    chk("irq cleared", 32'h0, 32'(irq));
    apb(1'b1, 8'hC4, 32'h0);
    measure('0);
    chk("irq masked", 32'h0, 32'(irq));
    close_out();
  end
endmodule
